// ---- hdl/ctt_defines.svh ----
// Offsets, field positions, reset values and timing figures
`ifndef CTT_DEFINES_SVH
`define CTT_DEFINES_SVH
`define CTT_CTRL_OFS 12'h000
`define CTT_STAT_OFS 12'h004
`define CTT_CTRL_W 14
`define CTT_STAT_W 13
`define CTT_B_REGRST 11
`define CTT_CTRL_RST 14'h025F
`define CTT_PH_OFF 2'h0
`define CTT_PH_PRE 2'h1
`define CTT_PH_FAST 2'h2
`define CTT_PH_DONE 2'h3
`define CTT_CF_TIMER 2'h3
`define CTT_TF_NONE 3'h0
`define CTT_TF_BCOLD 3'h5
`define CTT_TF_BHOT 3'h6
`define CTT_SRC_NONE 3'h0
`define CTT_SRC_OTG 3'h7
`define CTT_PCT_FULL 7'h64
`define CTT_PCT_HALF 7'h32
`define CTT_PCT_FIFTH 7'h14
`define CTT_PCT_ZERO 7'h00
`define CTT_CLK_NS 4
`define CTT_TICK_NS 1000000000
`define CTT_TICK_S 1
`define CTT_INT_US 256
`define CTT_LIM_LOW_S 7200
`define CTT_LIM_LONG_S 57600
`define CTT_LIM_SHORT_S 25200
`define CTT_TOP1_S 900
`define CTT_TOP2_S 1800
`define CTT_TOP3_S 2700
`endif

// ---- hdl/ctt_pkg.sv ----
// Types shared by the charge supervisor
package ctt_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PRE = 3'h1,
    S_FAST = 3'h3,
    S_TOPOFF = 3'h2,
    S_DONE = 3'h6,
    S_TFAULT = 3'h7
  } ctt_state_t;
  typedef enum logic [2:0] {
    Z_COLD = 3'h0,
    Z_COOL = 3'h1,
    Z_NORM = 3'h3,
    Z_WARM = 3'h2,
    Z_HOT = 3'h6
  } ctt_zone_t;
  typedef struct packed {
    logic [1:0] topoff_select;
    logic reg_reset;
    logic cool_voltage_select;
    logic cool_current_enable;
    logic cool_current_select;
    logic [1:0] warm_current_select;
    logic warm_voltage_select;
    logic half_rate_enable;
    logic safety_timer_length;
    logic timer_enable;
    logic term_enable;
    logic charge_enable_bit;
  } ctt_ctrl_t;
  typedef struct packed {
    logic input_voltage_limit_flag;
    logic input_current_limit_flag;
    logic [2:0] temperature_fault_field;
    logic [2:0] input_source_status;
    logic [1:0] charge_fault_field;
    logic topoff_running_flag;
    logic [1:0] charge_phase_status;
  } ctt_stat_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ctt_apb_t;
  typedef struct packed {
    logic vbat_above_rechg;
    logic vbat_below_vreg;
    logic vbat_above_prechg;
    logic vbat_above_lowbat;
    logic ichg_below_term;
    logic iin_limit;
    logic vin_limit;
    logic thermal_reg;
    logic supplement;
    logic fault;
    logic ts_above_vt1;
    logic ts_above_vt2;
    logic ts_above_vt3;
    logic ts_above_vt4;
    logic boost_req;
    logic ts_above_bcold;
    logic ts_above_bhot;
    logic [2:0] vbus_source;
  } ctt_meas_t;
  typedef struct packed {
    ctt_state_t state;
    ctt_zone_t zone;
    ctt_ctrl_t ctrl;
    logic [27:0] tick_cnt;
    logic tick_half;
    logic [15:0] safe_cnt;
    logic lowbat_seen;
    logic [11:0] top_cnt;
    logic [1:0] top_lat;
    logic [1:0] chg_fault;
    logic en_q;
    logic int_low;
    logic int_pend;
    logic [15:0] int_cnt;
    logic [6:0] ichg_pct;
    logic vclamp;
    logic boost_on;
    logic [2:0] tfault;
    logic [31:0] rdata;
    logic slverr;
  } ctt_st_t;
endpackage : ctt_pkg

// ---- hdl/ctt_charge_supervisor.sv ----
// Charge termination, temperature zones, safety timer and host pulse
// Notes on behaviour
// - Terminate above recharge level, current below termination
// - Termination shows phase 11 and pulses interrupt
// - Input or thermal limiting holds off termination
// - Termination enable low blocks current termination
// - Nonzero top-off delay postpones termination, keeps CV
// - Top-off counter pauses and slows like safety timer
// - Status bit shows top-off counter running
// - Enable rise, termination rise, register reset clear top-off
// - Top-off setting latched at termination detection
// - Interrupt pulse at top-off start and end
// - Charge only inside T1-T4 window, else zero
// - Warm zone voltage clamp chosen by select bit
// - Warm zone current 0, 20 or 50 percent
// - Cool zone current 50/20 percent or none
// - Cool zone voltage clamp chosen by select bit
// - Boost suspends outside its window, fault field reports
// - Safety expiry stops charge, fault 11, interrupt
// - Limits 2h below low battery, 16h or 7h
// - Half rate under limiting or cool when enabled
// - Safety timer holds on fault, supplement, suspension
// - Restart or enable toggle clears safety timer
// - Input current and voltage limit flags
// - Phase codes 00 off, 01 pre, 10 fast, 11 done
// - Each interrupt is one 256 us low pulse
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ctt_defines.svh"
`default_nettype none
module ctt_charge_supervisor #(
  parameter int TICK_CYCLES = `CTT_TICK_NS / `CTT_CLK_NS,
  parameter int INT_PULSE_CYCLES = `CTT_INT_US * 1000 / `CTT_CLK_NS,
  parameter int LIM_LOW_TICKS = `CTT_LIM_LOW_S / `CTT_TICK_S,
  parameter int LIM_LONG_TICKS = `CTT_LIM_LONG_S / `CTT_TICK_S,
  parameter int LIM_SHORT_TICKS = `CTT_LIM_SHORT_S / `CTT_TICK_S
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire ctt_pkg::ctt_apb_t APB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire ctt_pkg::ctt_meas_t MEAS,
  input wire logic CHARGE_ENABLE_PIN_N,
  output logic HOST_INTERRUPT_N,
  output logic [6:0] CHARGE_CURRENT_PCT,
  output logic VREG_CLAMP_4V1,
  output logic CV_HOLD,
  output logic BOOST_ON,
  output logic CHARGING
);
  ctt_pkg::ctt_st_t st;
  ctt_pkg::ctt_st_t next_st;
  ctt_pkg::ctt_stat_t stat;
  logic acc;
  logic wr;
  logic reg_rst;
  logic tick;
  logic en;
  logic en_rise;
  logic win;
  logic dpm;
  logic slow;
  logic pause;
  logic adv;
  logic charging;
  logic term_ok;
  logic start_ok;
  logic expire;
  logic ev;
  logic bwin;
  logic [15:0] safe_lim;
  logic [11:0] top_lim;
  logic [11:0] top_lim_w;

  function automatic logic [11:0] top_ticks(input logic [1:0] sel);
    logic [11:0] t;
    t = 12'h000;
    case (sel)
      2'h1: t = 12'(`CTT_TOP1_S / `CTT_TICK_S);
      2'h2: t = 12'(`CTT_TOP2_S / `CTT_TICK_S);
      2'h3: t = 12'(`CTT_TOP3_S / `CTT_TICK_S);
      default: t = 12'h000;
    endcase
    return t;
  endfunction : top_ticks

  // Status word
  always_comb begin
    stat = '0;
    case (st.state)
      ctt_pkg::S_PRE: stat.charge_phase_status = `CTT_PH_PRE;
      ctt_pkg::S_FAST: stat.charge_phase_status = `CTT_PH_FAST;
      ctt_pkg::S_TOPOFF: stat.charge_phase_status = `CTT_PH_FAST;
      ctt_pkg::S_DONE: stat.charge_phase_status = `CTT_PH_DONE;
      default: stat.charge_phase_status = `CTT_PH_OFF;
    endcase
    stat.topoff_running_flag = st.state == ctt_pkg::S_TOPOFF;
    stat.charge_fault_field = st.chg_fault;
    stat.temperature_fault_field = st.tfault;
    if (st.boost_on) begin
      stat.input_source_status = `CTT_SRC_OTG;
    end else if (MEAS.boost_req) begin
      stat.input_source_status = `CTT_SRC_NONE;
    end else begin
      stat.input_source_status = MEAS.vbus_source;
    end
    stat.input_current_limit_flag = MEAS.iin_limit;
    stat.input_voltage_limit_flag = MEAS.vin_limit;
  end

  always_comb begin
    next_st = st;
    acc = APB.psel && APB.penable;
    wr = acc && APB.pwrite && APB.paddr == `CTT_CTRL_OFS;
    reg_rst = wr && APB.pwdata[`CTT_B_REGRST];
    // Register bus
    if (APB.psel && !APB.penable) begin
      next_st.slverr = 1'b0;
      next_st.rdata = 32'h00000000;
      case (APB.paddr)
        `CTT_CTRL_OFS: next_st.rdata = 32'(st.ctrl);
        `CTT_STAT_OFS: next_st.rdata = 32'(stat);
        default: next_st.slverr = 1'b1;
      endcase
    end
    if (reg_rst) begin
      next_st.ctrl = `CTT_CTRL_RST;
    end else if (wr) begin
      next_st.ctrl = APB.pwdata[`CTT_CTRL_W-1:0];
      next_st.ctrl.reg_reset = 1'b0;
    end
    // Prescaler
    tick = st.tick_cnt == 28'(TICK_CYCLES - 1);
    next_st.tick_cnt = tick ? 28'h0000000 : st.tick_cnt + 28'h0000001;
    if (tick) begin
      next_st.tick_half = !st.tick_half;
    end
    // Temperature zone
    if (MEAS.ts_above_vt1) begin
      next_st.zone = ctt_pkg::Z_COLD;
    end else if (MEAS.ts_above_vt2) begin
      next_st.zone = ctt_pkg::Z_COOL;
    end else if (MEAS.ts_above_vt3) begin
      next_st.zone = ctt_pkg::Z_NORM;
    end else if (MEAS.ts_above_vt4) begin
      next_st.zone = ctt_pkg::Z_WARM;
    end else begin
      next_st.zone = ctt_pkg::Z_HOT;
    end
    win = st.zone != ctt_pkg::Z_COLD && st.zone != ctt_pkg::Z_HOT;
    en = st.ctrl.charge_enable_bit && !CHARGE_ENABLE_PIN_N;
    en_rise = en && !st.en_q;
    next_st.en_q = en;
    dpm = MEAS.iin_limit || MEAS.vin_limit || MEAS.thermal_reg;
    slow = st.ctrl.half_rate_enable &&
      (dpm || st.zone == ctt_pkg::Z_COOL);
    pause = MEAS.fault || MEAS.supplement ||
      st.ichg_pct == `CTT_PCT_ZERO;
    adv = tick && !pause && (!slow || st.tick_half);
    charging = st.state == ctt_pkg::S_PRE ||
      st.state == ctt_pkg::S_FAST || st.state == ctt_pkg::S_TOPOFF;
    term_ok = st.ctrl.term_enable && MEAS.vbat_above_rechg &&
      MEAS.ichg_below_term && !dpm;
    start_ok = en && win && !MEAS.fault &&
      MEAS.vbat_below_vreg;
    top_lim_w = top_ticks(st.ctrl.topoff_select);
    top_lim = top_ticks(st.top_lat);
    if (!st.lowbat_seen) begin
      safe_lim = 16'(LIM_LOW_TICKS);
    end else if (st.ctrl.safety_timer_length) begin
      safe_lim = 16'(LIM_LONG_TICKS);
    end else begin
      safe_lim = 16'(LIM_SHORT_TICKS);
    end
    expire = charging && st.ctrl.timer_enable && adv &&
      st.safe_cnt >= safe_lim - 16'h0001;
    ev = 1'b0;
    // Charge sequence
    case (st.state)
      ctt_pkg::S_IDLE: begin
        if (start_ok) begin
          next_st.state = MEAS.vbat_above_prechg ?
            ctt_pkg::S_FAST : ctt_pkg::S_PRE;
          next_st.safe_cnt = 16'h0000;
          next_st.lowbat_seen = 1'b0;
          next_st.chg_fault = 2'h0;
        end
      end
      ctt_pkg::S_PRE: begin
        if (MEAS.vbat_above_prechg) begin
          next_st.state = ctt_pkg::S_FAST;
        end
      end
      ctt_pkg::S_FAST: begin
        if (term_ok && top_lim_w != 12'h000) begin
          next_st.state = ctt_pkg::S_TOPOFF;
          next_st.top_lat = st.ctrl.topoff_select;
          next_st.top_cnt = 12'h000;
          ev = 1'b1;
        end else if (term_ok) begin
          next_st.state = ctt_pkg::S_DONE;
          next_st.top_cnt = 12'h000;
          ev = 1'b1;
        end
      end
      ctt_pkg::S_TOPOFF: begin
        if (adv && st.top_cnt >= top_lim - 12'h001) begin
          next_st.state = ctt_pkg::S_DONE;
          next_st.top_cnt = 12'h000;
          ev = 1'b1;
        end else if (adv) begin
          next_st.top_cnt = st.top_cnt + 12'h001;
        end
      end
      ctt_pkg::S_DONE: begin
        if (!MEAS.vbat_above_rechg) begin
          next_st.state = MEAS.vbat_above_prechg ?
            ctt_pkg::S_FAST : ctt_pkg::S_PRE;
          next_st.safe_cnt = 16'h0000;
          next_st.lowbat_seen = 1'b0;
        end
      end
      ctt_pkg::S_TFAULT: begin
        next_st.state = ctt_pkg::S_TFAULT;
      end
      default: begin
        next_st.state = ctt_pkg::S_IDLE;
      end
    endcase
    // Safety timer
    if (charging && MEAS.vbat_above_lowbat) begin
      next_st.lowbat_seen = 1'b1;
    end
    if (expire) begin
      next_st.state = ctt_pkg::S_TFAULT;
      next_st.chg_fault = `CTT_CF_TIMER;
      ev = 1'b1;
    end else if (charging && st.ctrl.timer_enable && adv) begin
      next_st.safe_cnt = st.safe_cnt + 16'h0001;
    end
    if (!en) begin
      next_st.state = ctt_pkg::S_IDLE;
    end
    if (en_rise || reg_rst) begin
      next_st.top_cnt = 12'h000;
      next_st.safe_cnt = 16'h0000;
    end
    // Charge limits
    next_st.ichg_pct = `CTT_PCT_ZERO;
    next_st.vclamp = 1'b0;
    if (charging && win) begin
      case (st.zone)
        ctt_pkg::Z_COOL: begin
          if (st.ctrl.cool_current_enable) begin
            next_st.ichg_pct = st.ctrl.cool_current_select ?
              `CTT_PCT_FIFTH : `CTT_PCT_HALF;
          end
          next_st.vclamp = st.ctrl.cool_voltage_select;
        end
        ctt_pkg::Z_WARM: begin
          case (st.ctrl.warm_current_select)
            2'h0: next_st.ichg_pct = `CTT_PCT_ZERO;
            2'h1: next_st.ichg_pct = `CTT_PCT_FIFTH;
            default: next_st.ichg_pct = `CTT_PCT_HALF;
          endcase
          next_st.vclamp = !st.ctrl.warm_voltage_select;
        end
        default: begin
          next_st.ichg_pct = `CTT_PCT_FULL;
        end
      endcase
    end
    // Boost temperature window
    bwin = !MEAS.ts_above_bcold && MEAS.ts_above_bhot;
    next_st.boost_on = MEAS.boost_req && bwin;
    if (!MEAS.boost_req || bwin) begin
      next_st.tfault = `CTT_TF_NONE;
    end else if (MEAS.ts_above_bcold) begin
      next_st.tfault = `CTT_TF_BCOLD;
    end else begin
      next_st.tfault = `CTT_TF_BHOT;
    end
    // Host pulse
    if (st.int_low) begin
      next_st.int_pend = st.int_pend || ev;
      if (st.int_cnt == 16'(INT_PULSE_CYCLES - 1)) begin
        next_st.int_low = 1'b0;
      end else begin
        next_st.int_cnt = st.int_cnt + 16'h0001;
      end
    end else if (ev || st.int_pend) begin
      next_st.int_low = 1'b1;
      next_st.int_cnt = 16'h0000;
      next_st.int_pend = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
      st.ctrl <= `CTT_CTRL_RST;
      st.zone <= ctt_pkg::Z_COLD;
    end else begin
      st <= next_st;
    end
  end

  assign PREADY = acc;
  assign PSLVERR = acc && st.slverr;
  assign PRDATA = st.rdata;
  assign HOST_INTERRUPT_N = !st.int_low;
  assign CHARGE_CURRENT_PCT = st.ichg_pct;
  assign VREG_CLAMP_4V1 = st.vclamp;
  assign CV_HOLD = st.state == ctt_pkg::S_TOPOFF;
  assign BOOST_ON = st.boost_on;
  assign CHARGING = charging;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  sequence s_pulse_start;
    st.int_low && st.int_cnt == 16'h0000;
  endsequence
  sequence s_boost_off;
    !BOOST_ON && stat.input_source_status == `CTT_SRC_NONE;
  endsequence

  a_term_done: assert property (
    (st.state == ctt_pkg::S_FAST && en && term_ok &&
    top_lim_w == 12'h000 && !expire) |=> st.state == ctt_pkg::S_DONE)
    else $error("no termination");
  a_done_code: assert property (
    st.state == ctt_pkg::S_DONE |-> stat.charge_phase_status == 2'h3)
    else $error("bad phase");
  a_dpm_hold: assert property (
    (st.state == ctt_pkg::S_FAST && dpm) |=>
    st.state != ctt_pkg::S_DONE && st.state != ctt_pkg::S_TOPOFF)
    else $error("dpm term");
  a_term_off: assert property (
    (st.state == ctt_pkg::S_FAST && !st.ctrl.term_enable) |=>
    st.state != ctt_pkg::S_DONE && st.state != ctt_pkg::S_TOPOFF)
    else $error("term off");
  a_topoff_gate: assert property (
    (st.state == ctt_pkg::S_TOPOFF && !adv && !en_rise && !reg_rst) |=>
    $stable(st.top_cnt)) else $error("topoff ran");
  a_topoff_latch: assert property (
    st.state == ctt_pkg::S_TOPOFF |=> $stable(st.top_lat))
    else $error("topoff setting moved");
  a_int_start: assert property (
    (ev && !st.int_low) |=> s_pulse_start) else $error("no pulse");
  a_int_pend: assert property (
    (!st.int_low && st.int_pend) |=> s_pulse_start)
    else $error("pending pulse lost");
  a_int_width: assert property (
    (st.int_low && st.int_cnt == 16'(INT_PULSE_CYCLES - 1)) |=>
    !st.int_low) else $error("pulse width");
  a_int_hold: assert property (
    (st.int_low && st.int_cnt != 16'(INT_PULSE_CYCLES - 1)) |=>
    st.int_low && st.int_cnt == $past(st.int_cnt) + 16'h0001)
    else $error("pulse cut short");
  a_window_zero: assert property (
    !win |=> st.ichg_pct == `CTT_PCT_ZERO)
    else $error("current out of window");
  a_start_window: assert property (
    (st.state == ctt_pkg::S_IDLE && !win) |=> st.state == ctt_pkg::S_IDLE)
    else $error("start outside window");
  a_safe_fault: assert property (
    expire |=> (st.state == ctt_pkg::S_TFAULT && st.chg_fault == 2'h3) ||
    !$past(en)) else $error("timer fault");
  a_safe_pause: assert property (
    (charging && pause && !en_rise && !reg_rst) |=> $stable(st.safe_cnt))
    else $error("safety timer ran");
  a_enable_clear: assert property (
    (en_rise || reg_rst) |=>
    st.top_cnt == 12'h000 && st.safe_cnt == 16'h0000)
    else $error("counters not cleared");
  a_boost_susp: assert property (
    (MEAS.boost_req && !bwin) ##1 MEAS.boost_req |-> s_boost_off)
    else $error("boost not suspended");
  a_boost_resume: assert property (
    (MEAS.boost_req && bwin) |=>
    BOOST_ON && st.tfault == `CTT_TF_NONE) else $error("boost not resumed");
endmodule : ctt_charge_supervisor
`default_nettype wire

// ---- verif/ctt_host_model.sv ----
// Host model: APB master and interrupt pulse monitor
`timescale 1ns/1ps
`default_nettype none
module ctt_host_model (
  input wire logic clk,
  output var ctt_pkg::ctt_apb_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic int_n
);
  int n_pulse = 0;
  int width = 0;
  int cur = 0;
  initial apb = '0;
  // Low time of each host pulse
  always @(posedge clk) begin
    if (int_n === 1'b0) begin
      cur <= cur + 1;
    end else if (cur != 0) begin
      width <= cur;
      n_pulse <= n_pulse + 1;
      cur <= 0;
    end
  end
  // One transfer, held until pready at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask : xfer
endmodule : ctt_host_model
`default_nettype wire

// ---- verif/tb_charge_termination_thermal_timer_ctrl.sv ----
// Self-checking bench for the charge supervisor
`timescale 1ns/1ps
`include "ctt_defines.svh"
`default_nettype none
module tb_charge_termination_thermal_timer_ctrl;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic pin_n = 1'b1;
  ctt_pkg::ctt_meas_t meas = '0;
  ctt_pkg::ctt_apb_t apb;
  logic [31:0] prdata;
  logic pready, pslverr, int_n, cv_hold, boost_on, charging, clamp;
  logic [6:0] pct;
  logic [31:0] rd, c;
  logic [31:0] seed = 32'h38CA0602;
  logic err;
  int n_mismatch = 0;
  int checks_done = 0;
  int n, p0, z;
  always #2 clock = ~clock;
  ctt_charge_supervisor #(.TICK_CYCLES(4), .INT_PULSE_CYCLES(8),
    .LIM_LOW_TICKS(4), .LIM_LONG_TICKS(12), .LIM_SHORT_TICKS(6)) dut (
    .CLOCK(clock), .RESETN(resetn), .APB(apb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MEAS(meas),
    .CHARGE_ENABLE_PIN_N(pin_n), .HOST_INTERRUPT_N(int_n),
    .CHARGE_CURRENT_PCT(pct), .VREG_CLAMP_4V1(clamp), .CV_HOLD(cv_hold),
    .BOOST_ON(boost_on), .CHARGING(charging));
  ctt_host_model host (.clk(clock), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .int_n(int_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [6:0] exp_pct(input int z, input logic [31:0] c);
    case (z)
      1: return c[9] ? (c[8] ? 7'h14 : 7'h32) : 7'h00;
      2: return 7'h64;
      3: return (c[7:6] == 2'h0) ? 7'h00 : (c[7:6] == 2'h1 ? 7'h14 : 7'h32);
      default: return 7'h00;
    endcase
  endfunction : exp_pct
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc
  task automatic wr(input logic [31:0] d);
    host.xfer(1'b1, `CTT_CTRL_OFS, d, rd, err);
  endtask : wr
  task automatic rdst();
    host.xfer(1'b0, `CTT_STAT_OFS, 32'h0, rd, err);
  endtask : rdst
  task automatic set_zone(input int z);
    @(posedge clock);
    meas.ts_above_vt1 <= (z == 0);
    meas.ts_above_vt2 <= (z <= 1);
    meas.ts_above_vt3 <= (z <= 2);
    meas.ts_above_vt4 <= (z <= 3);
  endtask : set_zone
  task automatic restart();
    @(posedge clock);
    pin_n <= 1'b1;
    cyc(3);
    pin_n <= 1'b0;
    cyc(4);
  endtask : restart
  task automatic safety(input logic [31:0] d, input logic iin, lb,
      input int lo, hi);
    wr(d);
    @(posedge clock);
    meas.iin_limit <= iin;
    meas.vbat_above_lowbat <= lb;
    restart();
    cyc(lo);
    chk("charging early", 1, charging);
    n = lo;
    while (charging === 1'b1 && n < hi) begin
      @(posedge clock);
      n++;
    end
    chk("charging late", 0, charging);
    rdst();
    chk("charge fault", 3, rd[4:3]);
  endtask : safety
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    cyc(12);
    resetn <= 1'b1;
    host.xfer(1'b0, `CTT_CTRL_OFS, 32'h0, rd, err);
    chk("ctrl reset", 32'h025F, rd);
    host.xfer(1'b0, 12'h008, 32'h0, rd, err);
    chk("unmapped error", 1, err);
    rdst();
    chk("phase idle", 0, rd[1:0]);
    // Fast charge, termination blocked then held off
    meas.vbat_below_vreg <= 1'b1;
    meas.vbat_above_prechg <= 1'b1;
    set_zone(2);
    wr(32'h19);
    pin_n <= 1'b0;
    cyc(6);
    rdst();
    chk("phase fast", 2, rd[1:0]);
    meas.vbat_above_rechg <= 1'b1;
    meas.ichg_below_term <= 1'b1;
    cyc(20);
    rdst();
    chk("phase no term", 2, rd[1:0]);
    meas.iin_limit <= 1'b1;
    meas.vin_limit <= 1'b1;
    wr(32'h1B);
    cyc(10);
    rdst();
    chk("phase held", 2, rd[1:0]);
    chk("limit flags", 3, rd[12:11]);
    p0 = host.n_pulse;
    meas.iin_limit <= 1'b0;
    meas.vin_limit <= 1'b0;
    cyc(10);
    rdst();
    chk("phase done", 3, rd[1:0]);
    chk("limit flags off", 0, rd[12:11]);
    cyc(12);
    chk("pulse count", p0 + 1, host.n_pulse);
    chk("pulse width", 8, host.width);
    // Top-off delay
    meas.vbat_above_rechg <= 1'b0;
    meas.ichg_below_term <= 1'b0;
    restart();
    wr(32'h101B);
    p0 = host.n_pulse;
    meas.vbat_above_rechg <= 1'b1;
    meas.ichg_below_term <= 1'b1;
    cyc(6);
    chk("cv hold", 1, cv_hold);
    rdst();
    chk("topoff flag", 1, rd[2]);
    chk("phase in topoff", 2, rd[1:0]);
    wr(32'h301B);
    n = 0;
    while (cv_hold === 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    chk("topoff length", 1, n > 3540 && n < 3620);
    rdst();
    chk("phase after topoff", 3, rd[1:0]);
    chk("topoff flag off", 0, rd[2]);
    cyc(12);
    chk("topoff pulses", p0 + 2, host.n_pulse);
    // Temperature zones with random settings
    meas.vbat_above_rechg <= 1'b0;
    meas.ichg_below_term <= 1'b0;
    restart();
    for (int i = 0; i < 12; i++) begin
      c = 32'h1B | (xs() & 32'h7E0);
      z = (i < 5) ? i : int'(xs() % 5);
      wr(c);
      set_zone(z);
      cyc(4);
      chk("current pct", exp_pct(z, c), pct);
      if (z == 1) chk("cool clamp", c[10], clamp);
      if (z == 3) chk("warm clamp", !c[5], clamp);
    end
    // Boost window
    set_zone(2);
    pin_n <= 1'b1;
    meas.boost_req <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      meas.ts_above_bcold <= (i == 1);
      meas.ts_above_bhot <= (i != 2);
      cyc(3);
      chk("boost on", i % 3 == 0, boost_on);
      rdst();
      chk("boost status", {(i == 1) ? 3'h5 : (i == 2) ? 3'h6 : 3'h0,
        (i % 3 == 0) ? 3'h7 : 3'h0}, rd[10:5]);
    end
    meas.boost_req <= 1'b0;
    // Safety timer limits and half rate
    safety(32'h1F, 1'b0, 1'b0, 8, 24);
    safety(32'h1F, 1'b1, 1'b0, 22, 50);
    safety(32'h1F, 1'b0, 1'b1, 40, 70);
    safety(32'h17, 1'b0, 1'b1, 16, 36);
    give_verdict();
  end
endmodule : tb_charge_termination_thermal_timer_ctrl
`default_nettype wire
